//--- rtl/tdm_consts.vh
// Constants for the time-slot switch matrix control block
`ifndef TDM_CONSTS_VH
`define TDM_CONSTS_VH

// Command opcodes (low nibble of the command byte)
`define OP_CONNECT  4'h2
`define OP_DISC     4'h4
`define OP_INSERT   4'h6
`define OP_EXTRACT  4'h8
`define OP_STATUS   4'hA
`define OP_FAST     4'hE
// Command byte bit that requests the disconnect option
`define DISC_BIT    4

// Control memory entry modes, bits 9:8 of an entry
`define CM_FREE     2'h0
`define CM_INS      2'h1
`define CM_CONN     2'h2

// Frame layout
`define CH_LAST_EU  5'h1F
`define CH_LAST_NA  5'h17
`define SKIP_TAG    2'h1
`define IDLE_BYTE   8'hFF

// Ready pulse timing
`define RDY_PULSE_NS   500
`define SYS_PERIOD_NS  4
`define RDY_CYCLES     7'h7D

// Reset levels of the synchronised pins (strobes idle high)
`define SYNC_INIT   25'h0000700
`endif

//--- rtl/pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter         W    = 25,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // Clock, reset, enable
    input  wire         clk,
    input  wire         srst,
    input  wire         ce,
    // Raw pins and filtered levels
    input  wire [W-1:0] din,
    output reg  [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer i;

    // First stage feeds only the second; level moves once 2 and 3 agree
    always @(posedge clk) begin
        if (srst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q    <= INIT;
        end else if (ce) begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/channel0_stack.v
// Eight-entry store for extracted channel-0 words
`timescale 1ns/1ps
`default_nettype none
module channel0_stack (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    // Fill and drain
    input  wire        clr,
    input  wire        push,
    input  wire [10:0] push_word,
    input  wire        pop,
    output wire [10:0] top,
    output reg  [3:0]  count
);
    reg [10:0] mem [0:7];
    reg [2:0]  wr_r;
    reg [2:0]  rd_r;

    // Entries leave in the order they were pushed
    assign top = mem[rd_r];

    // Pointer and count upkeep; clear restarts a scan
    always @(posedge clk) begin
        if (srst) begin
            wr_r  <= 3'h0;
            rd_r  <= 3'h0;
            count <= 4'h0;
        end else if (ce) begin
            if (clr) begin
                wr_r  <= 3'h0;
                rd_r  <= 3'h0;
                count <= 4'h0;
            end else if (push) begin
                wr_r  <= wr_r + 3'h1;
                count <= count + 4'h1;
            end else if (pop && count != 4'h0) begin
                rd_r  <= rd_r + 3'h1;
                count <= count - 4'h1;
            end
        end
    end

    // Storage has no reset; pointers guard stale words
    always @(posedge clk) begin
        if (ce && push && !clr) begin
            mem[wr_r] <= push_word;
        end
    end
endmodule
`default_nettype wire

//--- rtl/tdm_switch_matrix_control.v
// Time-slot switch matrix with host command port
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_consts.vh"
module tdm_switch_matrix_control (
    // Clock, reset, enable
    input  wire       sys_clk,
    input  wire       srst,
    input  wire       ce,
    // Host parallel port
    input  wire       cs_n,
    input  wire       wr_n,
    input  wire       rd_n,
    input  wire       cmd_sel,
    input  wire [7:0] d_in,
    output reg  [7:0] d_out,
    output reg        d_oe,
    output reg        extract_ready_n,
    // PCM highways
    input  wire       pcm_clk,
    input  wire       frame_sync,
    input  wire [7:0] pcm_in,
    output reg  [7:0] pcm_out,
    // Static mode pins
    input  wire       na_mode,
    input  wire       na_fbit,
    input  wire       matrix_mode
);
    // Next channel with wrap at the frame's last channel
    function [4:0] nxt_ch;
        input [4:0] ch;
        input [4:0] last;
        begin
            nxt_ch = (ch == last) ? 5'h00 : ch + 5'h01;
        end
    endfunction

    // Number of set bits, modulo eight
    function [2:0] pop3;
        input [7:0] m;
        integer k;
        begin
            pop3 = 3'h0;
            for (k = 0; k < 8; k = k + 1) begin
                pop3 = pop3 + {2'b00, m[k]};
            end
        end
    endfunction

    // Synchronised pins
    wire [24:0] s_q;
    pin_sync #(.W(25), .INIT(`SYNC_INIT)) u_sync (
        .clk  (sys_clk),
        .srst (srst),
        .ce   (ce),
        .din  ({matrix_mode, na_fbit, na_mode, frame_sync, pcm_clk,
                pcm_in, cmd_sel, rd_n, wr_n, cs_n, d_in}),
        .q    (s_q)
    );
    wire [7:0] h_d      = s_q[7:0];
    wire       h_cs_n   = s_q[8];
    wire       h_wr_n   = s_q[9];
    wire       h_rd_n   = s_q[10];
    wire       h_cd     = s_q[11];
    wire [7:0] p_in     = s_q[19:12];
    wire       p_clk    = s_q[20];
    wire       p_fs     = s_q[21];
    wire       m_na     = s_q[22];
    wire       m_fbit   = s_q[23];
    wire       m_matrix = s_q[24];

    // Memories: switched data (two frame banks) and control words
    reg [7:0] data_mem [0:511];
    reg [9:0] cm [0:255];

    // PCM timing state
    reg        pclk_q_r;
    reg        bank_r;
    reg [2:0]  bit_r;
    reg [4:0]  ch_r;
    reg        load_pend_r;
    reg [7:0]  in_sh [0:7];
    reg [6:0]  out_sh [0:7];
    reg [7:0]  out_next [0:7];
    // Fetch and scan state
    reg        fetch_on_r;
    reg [2:0]  fidx_r;
    reg [4:0]  fch_r;
    reg        scan_on_r;
    reg [2:0]  sidx_r;
    reg        scan_fin_r;
    // Host state
    reg        wr_q_r;
    reg        rd_q_r;
    reg        sel_r;
    reg        acd_r;
    reg [31:0] pb_r;
    reg        busy_r;
    reg [3:0]  op_r;
    reg [3:0]  stat_hi_r;
    reg [7:0]  word_r;
    reg        f4_pend_r;
    reg [4:0]  f4_ch_r;
    reg [2:0]  f4_hw_r;
    reg [7:0]  mask_r;
    reg        fast_on_r;
    reg        f6_ready_r;
    reg        phase_r;
    reg [6:0]  rdy_cnt_r;
    integer    h, hc, hf; // One loop index per process, no shared driver

    // Frame edges: F bit is dropped in 1544 framing
    wire [4:0] ch_last = m_na ? `CH_LAST_NA : `CH_LAST_EU;
    wire       rise    = ~pclk_q_r & p_clk;
    wire       fall    = pclk_q_r & ~p_clk;
    wire       fstart  = rise & p_fs;
    wire       fskip   = fstart & m_na & m_fbit;
    wire       take    = rise & ~fskip;
    wire [2:0] bit_eff = fstart ? 3'h0 : bit_r;
    wire [4:0] ch_eff  = fstart ? 5'h00 : ch_r;
    wire       in_wr   = take & (bit_eff == 3'h7);
    wire       load_go = fall & load_pend_r;

    // Host strobe ends, qualified by chip select at strobe start
    wire wr_start = wr_q_r & ~h_wr_n;
    wire rd_start = rd_q_r & ~h_rd_n;
    wire wr_end   = ~wr_q_r & h_wr_n & sel_r;
    wire rd_end   = ~rd_q_r & h_rd_n & sel_r;
    wire cmd_go   = wr_end & acd_r & ~busy_r;
    wire disc_opt = m_matrix & h_d[`DISC_BIT];

    // Stack ports
    wire [10:0] top;
    wire [3:0]  st_cnt;
    wire [7:0]  scan_w  = data_mem[{bank_r, sidx_r, 5'h00}];
    wire        s_push  = scan_on_r & mask_r[sidx_r] &
                          (scan_w[7:6] != `SKIP_TAG);
    wire        scan_go = in_wr & (ch_eff == 5'h00) & fast_on_r &
                          ~busy_r & ~scan_on_r & (st_cnt == 4'h0);
    wire        s_pop   = rd_end & acd_r & f6_ready_r & phase_r;

    channel0_stack u_stack (
        .clk       (sys_clk),
        .srst      (srst),
        .ce        (ce),
        .clr       (scan_go),
        .push      (s_push),
        .push_word ({sidx_r, scan_w}),
        .pop       (s_pop),
        .top       (top),
        .count     (st_cnt)
    );

    // Control memory writes decoded from the command byte
    reg       cm_we;
    reg [7:0] cm_wa;
    reg [9:0] cm_wd;
    always @* begin
        cm_we = 1'b0;
        cm_wa = 8'h00;
        cm_wd = {`CM_FREE, 8'h00};
        if (cmd_go) begin
            case (h_d[3:0])
                `OP_CONNECT: begin
                    cm_we = 1'b1;
                    cm_wa = {pb_r[18:16], pb_r[28:24]};
                    if (!disc_opt) begin
                        cm_wd = {`CM_CONN, pb_r[2:0], pb_r[12:8]};
                    end
                end
                `OP_INSERT: begin
                    cm_we = 1'b1;
                    cm_wa = {pb_r[10:8], pb_r[20:16]};
                    if (!disc_opt) begin
                        cm_wd = {`CM_INS, pb_r[7:0]};
                    end
                end
                `OP_DISC: begin
                    cm_we = 1'b1;
                    cm_wa = {pb_r[2:0], pb_r[12:8]};
                end
                default: begin
                    cm_we = 1'b0;
                end
            endcase
        end
    end

    // Memory writes; no reset, contents are data only
    always @(posedge sys_clk) begin
        if (ce && cm_we) begin
            cm[cm_wa] <= cm_wd;
        end
        if (ce && in_wr) begin
            for (h = 0; h < 8; h = h + 1) begin
                data_mem[{bank_r, h[2:0], ch_eff}] <=
                    {in_sh[h][6:0], p_in[h]};
            end
        end
    end

    // Bit and channel counting, serial in and out
    always @(posedge sys_clk) begin
        if (srst) begin
            pclk_q_r    <= 1'b0;
            bank_r      <= 1'b0;
            bit_r       <= 3'h0;
            ch_r        <= 5'h00;
            load_pend_r <= 1'b0;
            pcm_out     <= `IDLE_BYTE;
            for (hc = 0; hc < 8; hc = hc + 1) begin
                in_sh[hc]  <= 8'h00;
                out_sh[hc] <= 7'h7F;
            end
        end else if (ce) begin
            pclk_q_r <= p_clk;
            if (fstart) begin
                bank_r <= ~bank_r;
                bit_r  <= 3'h0;
                ch_r   <= 5'h00;
            end
            if (take) begin
                bit_r <= bit_eff + 3'h1;
                for (hc = 0; hc < 8; hc = hc + 1) begin
                    in_sh[hc] <= {in_sh[hc][6:0], p_in[hc]};
                end
                if (bit_eff == 3'h7) begin
                    ch_r        <= nxt_ch(ch_eff, ch_last);
                    load_pend_r <= 1'b1;
                end
            end
            // Outputs change on the falling bit edge, MSB first
            if (fall) begin
                load_pend_r <= 1'b0;
                for (hc = 0; hc < 8; hc = hc + 1) begin
                    if (load_pend_r) begin
                        pcm_out[hc] <= out_next[hc][7];
                        out_sh[hc]  <= out_next[hc][6:0];
                    end else begin
                        pcm_out[hc] <= out_sh[hc][6];
                        out_sh[hc]  <= {out_sh[hc][5:0], 1'b1};
                    end
                end
            end
        end
    end

    // Fetch next output bytes and scan channel 0 words
    reg [9:0] f_ent;
    always @* begin
        f_ent = cm[{fidx_r, fch_r}];
    end
    always @(posedge sys_clk) begin
        if (srst) begin
            fetch_on_r <= 1'b0;
            fidx_r     <= 3'h0;
            fch_r      <= 5'h00;
            scan_on_r  <= 1'b0;
            sidx_r     <= 3'h7;
            scan_fin_r <= 1'b0;
            for (hf = 0; hf < 8; hf = hf + 1) begin
                out_next[hf] <= `IDLE_BYTE;
            end
        end else if (ce) begin
            scan_fin_r <= 1'b0;
            if (load_go) begin
                fetch_on_r <= 1'b1;
                fidx_r     <= 3'h0;
                fch_r      <= nxt_ch(ch_r, ch_last);
            end else if (fetch_on_r) begin
                // Connected data comes from the previous frame's bank
                case (f_ent[9:8])
                    `CM_CONN: out_next[fidx_r] <=
                        data_mem[{~bank_r, f_ent[7:0]}];
                    `CM_INS:  out_next[fidx_r] <= f_ent[7:0];
                    default:  out_next[fidx_r] <= `IDLE_BYTE;
                endcase
                fidx_r <= fidx_r + 3'h1;
                if (fidx_r == 3'h7) begin
                    fetch_on_r <= 1'b0;
                end
            end
            // Highest highway first, one per cycle
            if (scan_go) begin
                scan_on_r <= 1'b1;
                sidx_r    <= 3'h7;
            end else if (scan_on_r) begin
                sidx_r <= sidx_r - 3'h1;
                if (sidx_r == 3'h0) begin
                    scan_on_r  <= 1'b0;
                    scan_fin_r <= 1'b1;
                end
            end
        end
    end

    // Host port: parameter bytes, commands, reads, ready pulse
    wire [9:0] st_ent  = cm[{pb_r[2:0], pb_r[12:8]}];
    wire       f4_hit  = load_go & f4_pend_r & (ch_r == f4_ch_r);
    wire       last_pr = (st_cnt == 4'h1);
    always @(posedge sys_clk) begin
        if (srst) begin
            wr_q_r          <= 1'b1;
            rd_q_r          <= 1'b1;
            sel_r           <= 1'b0;
            acd_r           <= 1'b0;
            pb_r            <= 32'h00000000;
            busy_r          <= 1'b0;
            op_r            <= 4'h0;
            stat_hi_r       <= 4'h0;
            word_r          <= 8'h00;
            f4_pend_r       <= 1'b0;
            f4_ch_r         <= 5'h00;
            f4_hw_r         <= 3'h0;
            mask_r          <= 8'h00;
            fast_on_r       <= 1'b0;
            f6_ready_r      <= 1'b0;
            phase_r         <= 1'b0;
            rdy_cnt_r       <= 7'h00;
            extract_ready_n <= 1'b1;
            d_out           <= 8'h00;
            d_oe            <= 1'b0;
        end else if (ce) begin
            wr_q_r <= h_wr_n;
            rd_q_r <= h_rd_n;
            if (wr_start || rd_start) begin
                sel_r <= ~h_cs_n;
                acd_r <= h_cd;
            end
            // Data bytes queue up; newest sits in the low byte
            if (wr_end && !acd_r) begin
                pb_r <= {pb_r[23:0], h_d};
            end
            if (f4_hit) begin
                word_r    <= out_next[f4_hw_r];
                f4_pend_r <= 1'b0;
            end
            if (cmd_go) begin
                busy_r <= 1'b1;
                op_r   <= h_d[3:0];
                case (h_d[3:0])
                    `OP_EXTRACT: begin
                        f4_pend_r <= 1'b1;
                        f4_ch_r   <= pb_r[12:8];
                        f4_hw_r   <= pb_r[2:0];
                    end
                    `OP_STATUS: begin
                        word_r    <= st_ent[7:0];
                        stat_hi_r <= {st_ent[9:8], 2'b00};
                    end
                    `OP_FAST: begin
                        mask_r    <= {pb_r[10:8], pb_r[4:0]};
                        fast_on_r <= ({pb_r[10:8], pb_r[4:0]} != 8'h00);
                        stat_hi_r <= {pop3({pb_r[10:8], pb_r[4:0]}),
                                      ({pb_r[10:8], pb_r[4:0]} != 8'h00)};
                    end
                    default: begin
                        stat_hi_r <= 4'h0;
                    end
                endcase
            end
            // Read data is set up at strobe start and held to its end
            if (rd_start && !h_cs_n) begin
                d_oe <= 1'b1;
                if (!h_cd) begin
                    d_out <= f6_ready_r ? top[7:0] : word_r;
                end else if (f6_ready_r && phase_r) begin
                    d_out <= {top[10:8], ~last_pr, `OP_FAST};
                end else if (f6_ready_r) begin
                    d_out <= {st_cnt[2:0], 1'b1, `OP_FAST};
                end else begin
                    d_out <= {stat_hi_r, op_r};
                end
            end
            // Read ends: status read releases busy and pops a pair
            if (rd_end) begin
                d_oe <= 1'b0;
                if (acd_r) begin
                    busy_r  <= 1'b0;
                    phase_r <= 1'b0;
                    if (s_pop && last_pr) begin
                        f6_ready_r <= 1'b0;
                    end
                end else if (f6_ready_r) begin
                    phase_r <= 1'b1;
                end
            end
            // Ready pulse; a set here wins over a same-cycle clear
            if (rdy_cnt_r != 7'h00) begin
                rdy_cnt_r <= rdy_cnt_r - 7'h01;
                if (rdy_cnt_r == 7'h01) begin
                    extract_ready_n <= 1'b1;
                end
            end
            if (scan_fin_r && st_cnt != 4'h0) begin
                f6_ready_r      <= 1'b1;
                phase_r         <= 1'b0;
                extract_ready_n <= 1'b0;
                rdy_cnt_r       <= `RDY_CYCLES;
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/tdm_switch_matrix_control_chk.sv
// Port checker for the switch matrix control block
`timescale 1ns/1ps
`default_nettype none
module tdm_switch_matrix_control_chk (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       srst,
    // Host port
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic [7:0] d_out,
    input wire logic       d_oe,
    input wire logic       extract_ready_n,
    // PCM side
    input wire logic       pcm_clk,
    input wire logic [7:0] pcm_out
);
    logic [7:0] low_cnt_r;
    logic [7:0] rd_hist_r;

    // Ready pulse length and recent selected reads; pins lag by sync
    always @(posedge sys_clk) begin
        if (srst) begin
            low_cnt_r <= 8'h00;
            rd_hist_r <= 8'h00;
        end else begin
            low_cnt_r <= extract_ready_n ? 8'h00 : low_cnt_r + 8'h01;
            rd_hist_r <= {rd_hist_r[6:0], ~rd_n & ~cs_n};
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_reset_idle: assert property ($fell(srst) |-> !d_oe && extract_ready_n
        && d_out == 8'h00 && pcm_out == 8'hFF) else $error("not idle");
    a_ready_width: assert property ($rose(extract_ready_n) |->
        low_cnt_r == 8'h7D) else $error("ready pulse length");
    a_ready_max: assert property (!extract_ready_n |->
        low_cnt_r < 8'h7D) else $error("ready pulse too long");
    a_oe_on_read: assert property (d_oe |-> rd_hist_r != 8'h00
        || (!rd_n && !cs_n)) else $error("bus driven without read");
    a_oe_release: assert property ($rose(rd_n) |-> ##[1:8] !d_oe)
        else $error("bus not released");
    a_no_oe_write: assert property (!wr_n |-> !d_oe)
        else $error("bus driven during write");
    a_dout_hold: assert property ($changed(d_out) |->
        rd_hist_r != 8'h00) else $error("read data moved between reads");
    a_pcm_on_fall: assert property ($changed(pcm_out) |-> !pcm_clk)
        else $error("highway output changed while bit clock high");
endmodule

bind tdm_switch_matrix_control tdm_switch_matrix_control_chk chk (
    .sys_clk, .srst, .cs_n, .wr_n, .rd_n, .d_out, .d_oe,
    .extract_ready_n, .pcm_clk, .pcm_out);
`default_nettype wire

//--- bench/host_model.sv
// Host processor model for the parallel command port
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       sys_clk,
    // Parallel port
    output logic            cs_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic            cmd_sel,
    output logic [7:0]      d_in,
    input  wire logic [7:0] d_out,
    input  wire logic       d_oe
);
    localparam int HOLD = 10;
    localparam int GAP  = 16;

    // Idle bus at time zero
    initial begin
        cs_n    = 1'b1;
        wr_n    = 1'b1;
        rd_n    = 1'b1;
        cmd_sel = 1'b0;
        d_in    = 8'h00;
    end

    // Write one byte; qualifiers outlive the strobe for the pin sync
    task automatic wr(input logic sel, input logic [7:0] b);
        @(posedge sys_clk);
        cs_n    <= 1'b0;
        cmd_sel <= sel;
        d_in    <= b;
        wr_n    <= 1'b0;
        repeat (HOLD) @(posedge sys_clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        d_in <= ~b;
        repeat (GAP) @(posedge sys_clk);
    endtask

    // Read one byte, taken at the last edge of the strobe
    task automatic rd(input logic sel, output logic [7:0] b,
                      output logic oe);
        @(posedge sys_clk);
        cs_n    <= 1'b0;
        cmd_sel <= sel;
        rd_n    <= 1'b0;
        repeat (HOLD) @(posedge sys_clk);
        b = d_out;
        oe = d_oe;
        rd_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        repeat (GAP) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

//--- bench/tdm_switch_matrix_control_test.sv
// Self-checking bench for the switch matrix control block
`timescale 1ns/1ps
`default_nettype none
module tdm_switch_matrix_control_test;
    localparam int FRAME = 4096;  // 256 bits of 16 cycles
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        pcm_clk = 1'b1;
    logic        frame_sync = 1'b0;
    logic [7:0]  pcm_in = 8'hFF;
    logic [3:0]  div_r = 4'h0;
    logic [7:0]  bit_r = 8'hFF;
    logic        matrix_pin = 1'b0;
    logic [15:0] tbl [2] = '{16'hDFE0, 16'h2589};
    wire         cs_n, wr_n, rd_n, cmd_sel, d_oe, extract_ready_n;
    wire  [7:0]  d_in, d_out, pcm_out;
    int          miscompares = 0;
    int          n_compared = 0;

    // Word on input channel c of highway h; channel 0 of 2 and 3 is 01xx
    function automatic logic [7:0] pat(input int h, input int c);
        return {h[2:0], c[4:0] ^ 5'h1F};
    endfunction

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // Bit clock at a sixteenth of sys_clk; data moves on its fall
    always @(posedge sys_clk) begin
        div_r <= div_r + 4'h1;
        if (div_r == 4'hF)
            pcm_clk <= 1'b1;
        if (div_r == 4'h7) begin
            pcm_clk    <= 1'b0;
            bit_r      <= bit_r + 8'h01;
            frame_sync <= (bit_r == 8'hFF);
            for (int h = 0; h < 8; h++)
                pcm_in[h] <= pat(h, bit_r[7:3] + ((bit_r[2:0] == 3'h7) ?
                    5'h01 : 5'h00)) >> (3'h7 - (bit_r[2:0] + 3'h1));
        end
    end

    tdm_switch_matrix_control dut (
        .sys_clk(sys_clk), .srst(srst), .ce(1'b1), .cs_n(cs_n),
        .wr_n(wr_n), .rd_n(rd_n), .cmd_sel(cmd_sel), .d_in(d_in),
        .d_out(d_out), .d_oe(d_oe), .extract_ready_n(extract_ready_n),
        .pcm_clk(pcm_clk), .frame_sync(frame_sync), .pcm_in(pcm_in),
        .pcm_out(pcm_out), .na_mode(1'b0), .na_fbit(1'b0),
        .matrix_mode(matrix_pin));

    host_model host (
        .sys_clk(sys_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .cmd_sel(cmd_sel), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));

    task automatic cmp(input logic [7:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %h not %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Parameter bytes, oldest first, then the command byte
    task automatic func(input logic [31:0] p, input int n,
                        input logic [7:0] op);
        for (int i = n - 1; i >= 0; i--)
            host.wr(1'b0, p[8*i +: 8]);
        host.wr(1'b1, op);
    endtask

    // Read and compare under a mask; the device must drive the bus
    task automatic rchk(input logic sel, input logic [7:0] exp, msk);
        logic [7:0] b;
        logic       oe;
        host.rd(sel, b, oe);
        cmp({7'h00, oe}, 8'h01, "bus drive");
        cmp(b & msk, exp, "read byte");
    endtask

    // Serial byte on output channel ch of highway hw, MSB first
    task automatic pcm_chk(input int hw, ch, input logic [7:0] exp);
        logic [7:0] b;
        while (div_r != 4'hF || bit_r != 8'(8 * ch))
            @(posedge sys_clk);
        for (int j = 7; j >= 0; j--) begin
            b[j] = pcm_out[hw];
            repeat (16) @(posedge sys_clk);
        end
        cmp(b, exp, "highway byte");
    endtask

    // Status then extract of output channel o = {ch, hw}
    task automatic probe(input logic [15:0] o, input logic [7:0] st,
                         dat, ext);
        func({16'h0000, o}, 2, 8'h0A);
        rchk(1'b1, st, 8'hFF);
        rchk(1'b0, dat, 8'hFF);
        func({16'h0000, o}, 2, 8'h08);
        rchk(1'b1, 8'h08, 8'h0F);
        pcm_chk(o[2:0], o[12:8], ext);
        rchk(1'b0, ext, 8'hFF);
    endtask

    // Two paths, one at the channel limits, then release one
    task automatic t_connect();
        logic [15:0] e;
        for (int i = 0; i < 2; i++) begin
            e = tbl[i];
            func({3'h0, e[4:0], 5'h00, e[7:5], 3'h0, e[12:8], 5'h00,
                  e[15:13]}, 4, i ? 8'h12 : 8'h02);
            rchk(1'b1, 8'h02, 8'h0F);
        end
        repeat (2 * FRAME) @(posedge sys_clk);
        for (int i = 0; i < 2; i++) begin
            e = tbl[i];
            probe({3'h0, e[4:0], 5'h00, e[7:5]}, 8'h8A, e[15:8],
                  pat(e[15:13], e[12:8]));
        end
        func({16'h0000, 8'h00, 8'h07}, 2, 8'h04);
        rchk(1'b1, 8'h04, 8'h0F);
        repeat (2 * FRAME) @(posedge sys_clk);
        probe(16'h0007, 8'h0A, 8'h00, 8'hFF);
    endtask

    // Insert a byte; a busy command is dropped; matrix option frees
    task automatic t_insert();
        func({8'h00, 8'h03, 8'h06, 8'h5A}, 3, 8'h06);
        host.wr(1'b1, 8'h04);
        rchk(1'b1, 8'h06, 8'h0F);
        probe(16'h0306, 8'h4A, 8'h5A, 8'h5A);
        matrix_pin <= 1'b1;
        func({8'h00, 8'h03, 8'h06, 8'h00}, 3, 8'h16);
        rchk(1'b1, 8'h06, 8'h0F);
        probe(16'h0306, 8'h0A, 8'h00, 8'hFF);
        matrix_pin <= 1'b0;
    endtask

    // Fast channel-0 extraction under highway mask m
    task automatic t_fast(input logic [7:0] m);
        int         q[$];
        int         n;
        int         k;
        logic [2:0] hw;
        for (int h = 7; h >= 0; h--)
            if (m[h] && pat(h, 0) >> 6 != 8'h01)
                q.push_back(h);
        n = $countones(m);
        k = q.size();
        func({16'h0000, 5'h00, m[7:5], 3'h0, m[4:0]}, 2, 8'h0E);
        rchk(1'b1, {n[2:0], 1'b1, 4'hE}, 8'hFF);
        n = 0;
        while (extract_ready_n !== 1'b0 && n < 9000) begin
            @(posedge sys_clk);
            n++;
        end
        cmp({7'h00, extract_ready_n}, {7'h00, k == 0}, "ready");
        n = 0;
        while (extract_ready_n === 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (k == 0)
            return;
        cmp(n[7:0], 8'h7D, "ready low cycles");
        rchk(1'b1, {k[2:0], 1'b1, 4'hE}, 8'hFF);
        for (int i = 0; i < k; i++) begin
            hw = 3'(q[i]);
            rchk(1'b0, pat(q[i], 0), 8'hFF);
            rchk(1'b1, {hw, i < k - 1, 4'hE}, 8'hFF);
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        t_connect();
        t_insert();
        t_fast(8'h0C);
        t_fast(8'h0E);
        t_fast(8'hF0);
        conclude();
    end

    // Watchdog; the sequence needs about 50k cycles
    initial begin
        repeat (100000) @(posedge sys_clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
